/* two_wire_register_access_slave_tb.sv */
// self-checking bench: master and slave joined over the two-wire link
`timescale 1ns/100ps
`default_nettype none
module two_wire_register_access_slave_tb;
  import twrs_pkg::*;
  localparam int HALF = 8;
  logic i_sys_clk = 1'h0;
  logic i_rst = 1'h1;
  logic strap = 1'h0;
  logic dis = 1'h0;
  logic cmd_valid = 1'h0;
  logic cmd_ready;
  twrs_op_t cmd_op = TWRS_OP_IDLE;
  logic [6:0] cmd_addr = 7'h00;
  twrs_byte_t cmd_index = 8'h00;
  twrs_byte_t cmd_data = 8'h00;
  logic rsp_valid;
  twrs_byte_t rsp_data;
  logic rsp_nack;
  logic wr_valid;
  logic wr_ready = 1'h1;
  twrs_byte_t wr_index;
  twrs_byte_t wr_data;
  logic rd_req;
  twrs_byte_t rd_index;
  logic rd_valid = 1'h0;
  twrs_byte_t rd_data = 8'h00;
  logic bus_busy;
  twrs_byte_t mem [256];
  logic [15:0] wr_q [$];
  logic [6:0] foreign [3] = '{7'h69, 7'h48, 7'h34};
  int failures = 0;
  int check_count = 0;
  int cycles = 0;
  twrs_link_if link ();
  twrs_master #(.HALF_CYC(HALF)) u_twrs_master (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .link(link.master),
    .i_cmd_valid(cmd_valid), .o_cmd_ready(cmd_ready), .i_cmd_op(cmd_op), .i_cmd_addr(cmd_addr),
    .i_cmd_index(cmd_index), .i_cmd_data(cmd_data), .o_rsp_valid(rsp_valid), .o_rsp_data(rsp_data),
    .o_rsp_nack(rsp_nack));
  twrs_slave u_twrs_slave (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .link(link.slave),
    .i_address_select_pin(strap), .i_two_wire_port_disable(dis), .o_wr_valid(wr_valid), .i_wr_ready(wr_ready),
    .o_wr_index(wr_index), .o_wr_data(wr_data), .o_rd_req(rd_req), .o_rd_index(rd_index),
    .i_rd_valid(rd_valid), .i_rd_data(rd_data), .o_bus_busy(bus_busy));
  twrs_link_monitor u_twrs_link_monitor (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .scl(link.scl), .sda(link.sda),
    .m_scl_oe_n(link.m_scl_oe_n), .m_sda_oe_n(link.m_sda_oe_n), .s_scl_oe_n(link.s_scl_oe_n),
    .s_sda_oe_n(link.s_sda_oe_n));
  always #20 i_sys_clk = ~i_sys_clk;
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
  end
  // register file behind the slave: takes writes, answers read requests
  always @(posedge i_sys_clk) begin
    rd_valid <= rd_req;
    rd_data <= mem[rd_index];
    if (wr_valid === 1'h1 && wr_ready === 1'h1) begin
      wr_q.push_back({wr_index, wr_data});
      mem[wr_index] <= wr_data;
    end
  end
  task automatic chk(input string name, input twrs_byte_t exp, input twrs_byte_t got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic conclude;
    if (failures == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude
  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      conclude();
    end
  end
  task automatic do_cmd(input twrs_op_t op, input logic [6:0] addr, input twrs_byte_t idx, input twrs_byte_t dat,
                        input logic exp_nack, input twrs_byte_t exp_rd, input logic busy_chk);
    int n;
    @(posedge i_sys_clk);
    cmd_op <= op;
    cmd_addr <= addr;
    cmd_index <= idx;
    cmd_data <= dat;
    cmd_valid <= 1'h1;
    for (n = 0; n < 100; n++) begin
      @(negedge i_sys_clk);
      if (cmd_ready === 1'h1) break;
    end
    @(posedge i_sys_clk);
    cmd_valid <= 1'h0;
    for (n = 0; n < 200 && busy_chk && bus_busy !== 1'h1; n++) @(negedge i_sys_clk);
    if (busy_chk) chk("bus_busy", 8'h01, {7'h0, bus_busy});
    for (n = 0; n < 2000 && rsp_valid !== 1'h1; n++) @(negedge i_sys_clk);
    chk("rsp_valid", 8'h01, {7'h0, rsp_valid});
    chk("rsp_nack", {7'h0, exp_nack}, {7'h0, rsp_nack});
    if (op == TWRS_OP_READ && !exp_nack) chk("rsp_data", exp_rd, rsp_data);
    for (n = 0; n < 20 && busy_chk && bus_busy !== 1'h0; n++) @(negedge i_sys_clk);
    if (busy_chk) chk("bus_busy_end", 8'h00, {7'h0, bus_busy});
  endtask : do_cmd
  task automatic chk_wr(input twrs_byte_t idx, input twrs_byte_t dat);
    int n;
    logic [15:0] w;
    for (n = 0; n < 50 && wr_q.size() == 0; n++) @(negedge i_sys_clk);
    w = (wr_q.size() != 0) ? wr_q.pop_front() : 16'hXXXX;
    chk("wr_index", idx, w[15:8]);
    chk("wr_data", dat, w[7:0]);
  endtask : chk_wr
  initial begin
    repeat (3) @(posedge i_sys_clk);
    i_rst <= 1'h0;
    do_cmd(TWRS_OP_WRITE, 7'h68, 8'h10, 8'hA5, 1'h0, 8'h00, 1'h1);
    chk_wr(8'h10, 8'hA5);
    do_cmd(TWRS_OP_READ, 7'h68, 8'h10, 8'h00, 1'h0, 8'hA5, 1'h1);
    do_cmd(TWRS_OP_READ, 7'h68, 8'h11, 8'h00, 1'h0, 8'h11 ^ 8'h5A, 1'h1);
    foreach (foreign[k]) do_cmd(TWRS_OP_WRITE, foreign[k], 8'h20, 8'h77, 1'h1, 8'h00, 1'h1);
    chk("wr_count", 8'h00, 8'(wr_q.size()));
    // receiver stalls: the buffer must keep the word until it is taken
    @(posedge i_sys_clk) wr_ready <= 1'h0;
    do_cmd(TWRS_OP_WRITE, 7'h68, 8'hFF, 8'h3C, 1'h0, 8'h00, 1'h1);
    chk("wr_valid", 8'h01, {7'h0, wr_valid});
    @(posedge i_sys_clk) wr_ready <= 1'h1;
    chk_wr(8'hFF, 8'h3C);
    @(posedge i_sys_clk) dis <= 1'h1;
    do_cmd(TWRS_OP_WRITE, 7'h68, 8'h30, 8'h55, 1'h1, 8'h00, 1'h0);
    chk("wr_count", 8'h00, 8'(wr_q.size()));
    @(posedge i_sys_clk) dis <= 1'h0;
    // strap is caught in reset, so the other address needs a second reset
    @(posedge i_sys_clk) strap <= 1'h1;
    i_rst <= 1'h1;
    repeat (3) @(posedge i_sys_clk);
    i_rst <= 1'h0;
    do_cmd(TWRS_OP_WRITE, 7'h69, 8'h00, 8'h00, 1'h0, 8'h00, 1'h1);
    chk_wr(8'h00, 8'h00);
    do_cmd(TWRS_OP_WRITE, 7'h68, 8'h40, 8'hC3, 1'h1, 8'h00, 1'h1);
    do_cmd(TWRS_OP_READ, 7'h69, 8'h00, 8'h00, 1'h0, 8'h00, 1'h1);
    conclude();
  end
endmodule : two_wire_register_access_slave_tb
`default_nettype wire

/* twrs_link_if.sv */
// open-drain two-wire link between master and slave
`timescale 1ns/100ps
`default_nettype none
interface twrs_link_if;
  logic m_scl_oe_n;
  logic m_sda_oe_n;
  logic s_scl_oe_n;
  logic s_sda_oe_n;
  logic scl;
  logic sda;
  // wired-and with pull-ups; an enable low pulls the line down
  assign scl = m_scl_oe_n & s_scl_oe_n;
  assign sda = m_sda_oe_n & s_sda_oe_n;
  modport slave (input scl, input sda, output s_scl_oe_n, output s_sda_oe_n);
  modport master (input scl, input sda, output m_scl_oe_n, output m_sda_oe_n);
endinterface : twrs_link_if
`default_nettype wire

/* twrs_link_monitor.sv */
// concurrent checks on the two-wire link between master and slave
`timescale 1ns/100ps
`default_nettype none
module twrs_link_monitor (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // link
  input wire logic scl,
  input wire logic sda,
  input wire logic m_scl_oe_n,
  input wire logic m_sda_oe_n,
  input wire logic s_scl_oe_n,
  input wire logic s_sda_oe_n
);
  logic scl_q_reg;
  logic sda_q_reg;
  logic busy_reg;
  logic [3:0] bit_cnt_reg;
  logic start_seen;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  assign start_seen = scl && scl_q_reg && sda_q_reg && !sda;
  always_ff @(posedge i_sys_clk) begin
    scl_q_reg <= scl;
    sda_q_reg <= sda;
  end
  // bus state as any listener sees it, independent of the slave's own view
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      busy_reg <= 1'h0;
    end else if (start_seen) begin
      busy_reg <= 1'h1;
    end else if (scl && scl_q_reg && !sda_q_reg && sda) begin
      busy_reg <= 1'h0;
    end
  end
  // a repeated start restarts the count, so the clock before it is harmless
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || start_seen) begin
      bit_cnt_reg <= 4'h0;
    end else if (scl && !scl_q_reg) begin
      bit_cnt_reg <= (bit_cnt_reg == 4'h8) ? 4'h0 : bit_cnt_reg + 4'h1;
    end
  end
  sequence s_ninth_rise;
    $rose(scl) && bit_cnt_reg == 4'h8;
  endsequence
  sequence s_high_changed;
    scl && $past(scl) && $changed(sda);
  endsequence
  property p_clk_by_master; $fell(scl) |-> !m_scl_oe_n; endproperty
  property p_cond_by_master; s_high_changed |-> $changed(m_sda_oe_n); endproperty
  property p_slave_sda_low; $changed(s_sda_oe_n) |-> !scl; endproperty
  property p_ack_held; ($rose(scl) && !s_sda_oe_n) |-> !s_sda_oe_n [*6]; endproperty
  property p_high_phase; $rose(scl) |-> scl [*6]; endproperty
  property p_low_phase; $fell(scl) |-> !scl [*6]; endproperty
  property p_idle_quiet; !busy_reg |-> (s_sda_oe_n && s_scl_oe_n); endproperty
  property p_ninth_release; s_ninth_rise |-> m_sda_oe_n; endproperty
  a_clk_by_master: assert property (p_clk_by_master) else $error("clock low not begun by master");
  a_cond_by_master: assert property (p_cond_by_master) else $error("sda moved with scl high");
  a_slave_sda_low: assert property (p_slave_sda_low) else $error("slave moved sda with scl high");
  a_ack_held: assert property (p_ack_held) else $error("slave low bit not held");
  a_high_phase: assert property (p_high_phase) else $error("scl high phase too short");
  a_low_phase: assert property (p_low_phase) else $error("scl low phase too short");
  a_idle_quiet: assert property (p_idle_quiet) else $error("slave drove an idle bus");
  a_ninth_release: assert property (p_ninth_release) else $error("master held sda on ninth clock");
endmodule : twrs_link_monitor
`default_nettype wire

/* twrs_map.svh */
// constants of the two-wire register access slave and its master
`ifndef TWRS_MAP_SVH
`define TWRS_MAP_SVH
`define TWRS_ADDR_HI 6'h34
`define TWRS_DIR_WRITE 1'h0
`define TWRS_DIR_READ 1'h1
`define TWRS_BITS_PER_BYTE 4'h8
`define TWRS_BIT_CNT_W 4
`define TWRS_CLK_HZ 25000000
`define TWRS_SCL_MAX_HZ 400000
`define TWRS_SCL_HALF_CYC ((`TWRS_CLK_HZ + 2 * `TWRS_SCL_MAX_HZ - 1) / (2 * `TWRS_SCL_MAX_HZ))
`define TWRS_IDX_RESET 8'h00
`define TWRS_BUF_DEPTH 2
`endif

/* twrs_master.sv */
// two-wire bus master issuing register writes and reads
`timescale 1ns/100ps
`default_nettype none
`include "twrs_map.svh"
module twrs_master #(
  parameter int HALF_CYC = `TWRS_SCL_HALF_CYC
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // link
  twrs_link_if.master link,
  // command
  input wire logic i_cmd_valid,
  output logic o_cmd_ready,
  input wire twrs_pkg::twrs_op_t i_cmd_op,
  input wire logic [6:0] i_cmd_addr,
  input wire twrs_pkg::twrs_byte_t i_cmd_index,
  input wire twrs_pkg::twrs_byte_t i_cmd_data,
  // answer
  output logic o_rsp_valid,
  output twrs_pkg::twrs_byte_t o_rsp_data,
  output logic o_rsp_nack
);
  import twrs_pkg::*;

  // each step of TWRS_M_BYTE sends or takes one byte plus its ack
  typedef enum {TWRS_M_IDLE, TWRS_M_START, TWRS_M_BYTE, TWRS_M_STOP} twrs_mstate_t;
  twrs_mstate_t state_reg;
  logic [15:0] tick_reg;
  logic [1:0] phase_reg;
  logic [3:0] bit_reg;
  logic [2:0] step_reg;
  twrs_byte_t tx_reg;
  twrs_byte_t rx_reg;
  logic scl_oe_n_reg, sda_oe_n_reg;
  logic rd_reg, nack_reg;
  twrs_byte_t idx_reg, dat_reg;
  logic [6:0] addr_reg;

  assign link.m_scl_oe_n = scl_oe_n_reg;
  assign link.m_sda_oe_n = sda_oe_n_reg;
  assign o_cmd_ready = state_reg == TWRS_M_IDLE;
  wire tick = tick_reg == 16'(HALF_CYC - 1);
  // wait while the slave stretches scl
  wire held = !scl_oe_n_reg ? 1'h0 : !link.scl;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst || tick || state_reg == TWRS_M_IDLE) begin
      tick_reg <= '0;
    end else if (!held) begin
      tick_reg <= tick_reg + 16'h0001;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      state_reg <= TWRS_M_IDLE;
      scl_oe_n_reg <= 1'h1;
      sda_oe_n_reg <= 1'h1;
      phase_reg <= '0;
      bit_reg <= '0;
      step_reg <= '0;
      tx_reg <= '0;
      rx_reg <= '0;
      rd_reg <= 1'h0;
      nack_reg <= 1'h0;
      idx_reg <= '0;
      dat_reg <= '0;
      addr_reg <= '0;
      o_rsp_valid <= 1'h0;
      o_rsp_data <= '0;
      o_rsp_nack <= 1'h0;
    end else begin
      o_rsp_valid <= 1'h0;
      unique case (state_reg)
        TWRS_M_IDLE: begin
          if (i_cmd_valid && i_cmd_op != TWRS_OP_IDLE) begin
            addr_reg <= i_cmd_addr;
            idx_reg <= i_cmd_index;
            dat_reg <= i_cmd_data;
            rd_reg <= i_cmd_op == TWRS_OP_READ;
            nack_reg <= 1'h0;
            step_reg <= '0;
            phase_reg <= '0;
            state_reg <= TWRS_M_START;
          end
        end
        TWRS_M_START: if (tick) begin
          // start or repeated start: sda falls while scl high
          phase_reg <= phase_reg + 2'h1;
          unique case (phase_reg)
            2'h0: begin sda_oe_n_reg <= 1'h1; scl_oe_n_reg <= 1'h1; end
            2'h1: sda_oe_n_reg <= 1'h0;
            2'h2: begin
              scl_oe_n_reg <= 1'h0;
              tx_reg <= {addr_reg, step_reg == 3'h2 ? `TWRS_DIR_READ : `TWRS_DIR_WRITE};
              bit_reg <= '0;
              phase_reg <= '0;
              state_reg <= TWRS_M_BYTE;
            end
            default: phase_reg <= '0;
          endcase
        end
        TWRS_M_BYTE: if (tick && !held) begin
          if (!scl_oe_n_reg) begin
            // scl low: drive next bit
            if (bit_reg < `TWRS_BITS_PER_BYTE) begin
              sda_oe_n_reg <= step_reg == 3'h3 ? 1'h1 : tx_reg[7];
              tx_reg <= {tx_reg[6:0], 1'h0};
            end else begin
              // ack slot: release sda after every byte, so a read byte is always nacked
              sda_oe_n_reg <= step_reg == 3'h3 ? 1'h1 : 1'h1;
            end
            scl_oe_n_reg <= 1'h1;
          end else begin
            if (bit_reg < `TWRS_BITS_PER_BYTE) begin
              rx_reg <= {rx_reg[6:0], link.sda};
              bit_reg <= bit_reg + 4'h1;
              scl_oe_n_reg <= 1'h0;
            end else begin
              scl_oe_n_reg <= 1'h0;
              bit_reg <= '0;
              if (step_reg != 3'h3 && link.sda) begin
                nack_reg <= 1'h1;
                state_reg <= TWRS_M_STOP;
              end else begin
                unique case (step_reg)
                  3'h0: begin tx_reg <= idx_reg; step_reg <= 3'h1; end
                  3'h1: begin
                    if (rd_reg) begin
                      step_reg <= 3'h2;
                      phase_reg <= '0;
                      state_reg <= TWRS_M_START;
                    end else begin
                      tx_reg <= dat_reg;
                      step_reg <= 3'h4;
                    end
                  end
                  3'h2: step_reg <= 3'h3;
                  3'h3: begin
                    o_rsp_data <= rx_reg;
                    state_reg <= TWRS_M_STOP;
                  end
                  default: state_reg <= TWRS_M_STOP;
                endcase
              end
            end
          end
        end
        TWRS_M_STOP: if (tick) begin
          // stop: sda rises while scl high
          phase_reg <= phase_reg + 2'h1;
          unique case (phase_reg)
            2'h0: sda_oe_n_reg <= 1'h0;
            2'h1: scl_oe_n_reg <= 1'h1;
            2'h2: begin
              sda_oe_n_reg <= 1'h1;
              o_rsp_valid <= 1'h1;
              o_rsp_nack <= nack_reg;
              phase_reg <= '0;
              state_reg <= TWRS_M_IDLE;
            end
            default: phase_reg <= '0;
          endcase
        end
      endcase
    end
  end
endmodule : twrs_master
`default_nettype wire

/* twrs_pkg.sv */
// types shared by both ends of the two-wire register access link
package twrs_pkg;
  typedef logic [7:0] twrs_byte_t;
  typedef enum logic [1:0] {TWRS_OP_WRITE, TWRS_OP_READ, TWRS_OP_IDLE} twrs_op_t;
endpackage : twrs_pkg

/* twrs_slave.sv */
// two-wire register access slave with register index, burst access and clock stretch
`timescale 1ns/100ps
`default_nettype none
`include "twrs_map.svh"
module twrs_slave (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // link
  twrs_link_if.slave link,
  // strap and mode
  input wire logic i_address_select_pin,
  input wire logic i_two_wire_port_disable,
  // register write stream out
  output logic o_wr_valid,
  input wire logic i_wr_ready,
  output twrs_pkg::twrs_byte_t o_wr_index,
  output twrs_pkg::twrs_byte_t o_wr_data,
  // register read stream in
  output logic o_rd_req,
  output twrs_pkg::twrs_byte_t o_rd_index,
  input wire logic i_rd_valid,
  input wire twrs_pkg::twrs_byte_t i_rd_data,
  // status
  output logic o_bus_busy
);
  import twrs_pkg::*;

  typedef enum {TWRS_S_IDLE, TWRS_S_ADDR, TWRS_S_ADDR_ACK, TWRS_S_INDEX, TWRS_S_INDEX_ACK,
    TWRS_S_WDATA, TWRS_S_WDATA_ACK, TWRS_S_FETCH, TWRS_S_RDATA, TWRS_S_RACK} twrs_sstate_t;

  twrs_sstate_t state_reg;
  logic scl_d_reg, sda_d_reg;
  logic [`TWRS_BIT_CNT_W-1:0] bit_cnt_reg;
  twrs_byte_t shift_reg;
  twrs_byte_t index_reg;
  logic addr_lsb_reg;
  logic busy_reg;
  logic sda_oe_n_reg;
  logic first_data_reg;
  logic dir_reg;
  // two-entry buffer towards the register file
  twrs_byte_t buf_data [`TWRS_BUF_DEPTH];
  twrs_byte_t buf_idx [`TWRS_BUF_DEPTH];
  logic buf_wp_reg, buf_rp_reg;
  logic [1:0] buf_cnt_reg;
  logic push;
  logic pop;

  wire en = ~i_two_wire_port_disable;
  wire scl_rise = en & link.scl & ~scl_d_reg;
  wire scl_fall = en & ~link.scl & scl_d_reg;
  wire start_c = en & link.scl & scl_d_reg & sda_d_reg & ~link.sda;
  wire stop_c = en & link.scl & scl_d_reg & ~sda_d_reg & link.sda;
  wire byte_done = bit_cnt_reg == `TWRS_BITS_PER_BYTE;
  wire buf_full = buf_cnt_reg == 2'(`TWRS_BUF_DEPTH);
  // hold scl until the ack is on sda or read data is loaded, so sda never moves with scl high
  wire stretch = en & ((state_reg == TWRS_S_WDATA_ACK && sda_oe_n_reg) || state_reg == TWRS_S_FETCH);

  assign link.s_scl_oe_n = ~stretch;
  assign link.s_sda_oe_n = sda_oe_n_reg;
  assign o_bus_busy = busy_reg;
  assign o_rd_req = state_reg == TWRS_S_FETCH;
  assign o_rd_index = index_reg;

  // strap caught each cycle in reset, not by the reset itself
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      addr_lsb_reg <= i_address_select_pin;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      scl_d_reg <= 1'h1;
      sda_d_reg <= 1'h1;
    end else begin
      scl_d_reg <= link.scl;
      sda_d_reg <= link.sda;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst || !en || stop_c) begin
      busy_reg <= 1'h0;
    end else if (start_c) begin
      busy_reg <= 1'h1;
    end
  end

  // sample on rising scl, shift out on falling scl
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || !en || stop_c) begin
      state_reg <= TWRS_S_IDLE;
      bit_cnt_reg <= '0;
      sda_oe_n_reg <= 1'h1;
      shift_reg <= '0;
      dir_reg <= `TWRS_DIR_WRITE;
      first_data_reg <= 1'h0;
    end else if (start_c) begin
      state_reg <= TWRS_S_ADDR;
      bit_cnt_reg <= '0;
      sda_oe_n_reg <= 1'h1;
    end else begin
      unique case (state_reg)
        TWRS_S_IDLE: begin
          sda_oe_n_reg <= 1'h1;
        end
        TWRS_S_ADDR, TWRS_S_INDEX, TWRS_S_WDATA: begin
          if (scl_rise) begin
            shift_reg <= {shift_reg[6:0], link.sda};
            bit_cnt_reg <= bit_cnt_reg + 1'h1;
          end else if (scl_fall && byte_done) begin
            bit_cnt_reg <= '0;
            if (state_reg == TWRS_S_ADDR) begin
              if (shift_reg[7:1] == {`TWRS_ADDR_HI, addr_lsb_reg}) begin
                sda_oe_n_reg <= 1'h0;
                dir_reg <= shift_reg[0];
                state_reg <= TWRS_S_ADDR_ACK;
              end else begin
                state_reg <= TWRS_S_IDLE;
              end
            end else if (state_reg == TWRS_S_INDEX) begin
              sda_oe_n_reg <= 1'h0;
              state_reg <= TWRS_S_INDEX_ACK;
            end else begin
              state_reg <= TWRS_S_WDATA_ACK;
            end
          end
        end
        TWRS_S_WDATA_ACK: begin
          // ack only once the byte is buffered
          if (!buf_full) begin
            sda_oe_n_reg <= 1'h0;
          end
          if (scl_fall && !sda_oe_n_reg) begin
            sda_oe_n_reg <= 1'h1;
            first_data_reg <= 1'h0;
            state_reg <= TWRS_S_WDATA;
          end
        end
        TWRS_S_ADDR_ACK: begin
          if (scl_fall) begin
            if (dir_reg == `TWRS_DIR_READ) begin
              state_reg <= TWRS_S_FETCH;
            end else begin
              sda_oe_n_reg <= 1'h1;
              state_reg <= TWRS_S_INDEX;
            end
          end
        end
        TWRS_S_INDEX_ACK: begin
          if (scl_fall) begin
            sda_oe_n_reg <= 1'h1;
            first_data_reg <= 1'h1;
            state_reg <= TWRS_S_WDATA;
          end
        end
        TWRS_S_FETCH: begin
          // scl is held low here, so sda may change
          if (i_rd_valid) begin
            shift_reg <= i_rd_data;
            sda_oe_n_reg <= i_rd_data[7];
            bit_cnt_reg <= 4'h1;
            state_reg <= TWRS_S_RDATA;
          end
        end
        TWRS_S_RDATA: begin
          if (scl_fall) begin
            if (byte_done) begin
              sda_oe_n_reg <= 1'h1;
              state_reg <= TWRS_S_RACK;
            end else begin
              shift_reg <= {shift_reg[6:0], 1'h0};
              sda_oe_n_reg <= shift_reg[6];
              bit_cnt_reg <= bit_cnt_reg + 1'h1;
            end
          end
        end
        TWRS_S_RACK: begin
          if (scl_rise && link.sda) begin
            state_reg <= TWRS_S_IDLE;
          end else if (scl_fall) begin
            // acked: stretch only once scl is low again
            state_reg <= TWRS_S_FETCH;
          end
        end
      endcase
    end
  end

  assign push = state_reg == TWRS_S_WDATA && scl_fall && byte_done && !buf_full;

  // a write byte that arrives with the buffer full waits in the ack stall
  logic pend_reg;
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      pend_reg <= 1'h0;
    end else begin
      pend_reg <= state_reg == TWRS_S_WDATA && scl_fall && byte_done && buf_full
        ? 1'h1 : (pend_reg && buf_full);
    end
  end
  wire late_push = pend_reg && !buf_full;

  // index loads from the index byte, advances per stored byte after the first or per acked read byte
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      index_reg <= `TWRS_IDX_RESET;
    end else if (state_reg == TWRS_S_INDEX && scl_fall && byte_done) begin
      index_reg <= shift_reg;
    end else if ((push || late_push) && !first_data_reg) begin
      index_reg <= index_reg + 8'h01;
    end else if (state_reg == TWRS_S_RACK && scl_rise && !link.sda) begin
      index_reg <= index_reg + 8'h01;
    end
  end

  assign pop = o_wr_valid && i_wr_ready;
  assign o_wr_valid = buf_cnt_reg != 2'h0;
  assign o_wr_data = buf_data[buf_rp_reg];
  assign o_wr_index = buf_idx[buf_rp_reg];

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      buf_wp_reg <= 1'h0;
      buf_rp_reg <= 1'h0;
      buf_cnt_reg <= 2'h0;
    end else begin
      if (push || late_push) begin
        buf_data[buf_wp_reg] <= shift_reg;
        buf_idx[buf_wp_reg] <= first_data_reg ? index_reg : index_reg + 8'h01;
        buf_wp_reg <= ~buf_wp_reg;
      end
      if (pop) begin
        buf_rp_reg <= ~buf_rp_reg;
      end
      buf_cnt_reg <= buf_cnt_reg + 2'((push || late_push) ? 1 : 0) - 2'(pop ? 1 : 0);
    end
  end
endmodule : twrs_slave
`default_nettype wire
